// file: rtl/dma_pci_master.sv
// bus-master front end of the dma function, with a retry-only target
// assumes all bus inputs are synchronous to clk_i; pins resolved outside
`timescale 1ns/1ps
// Summary of operation
// - long reads: memory read, multiple or line
// - writes use memory write or write-invalidate
// - long read command chosen by enhance field
// - one or two phase reads: plain memory read
// - both initiator and target signals implemented
// - functions 0,1,2 drive separate interrupt pins
// - all drivers released while global reset held
module dma_pci_master #(
	parameter logic [31:0] TGT_BASE = 32'h0000_0000,  // target window base
	parameter logic [31:0] TGT_MASK = 32'hFFFF_F000   // target window mask
) (
	input  wire logic                       clk_i,          // bus clock
	input  wire logic                       rst_b_i,        // global reset
	input  wire logic                       req_valid_i,    // dma request
	input  wire dma_master_pkg::dma_req_t   req_i,          // request body
	output logic                            req_ready_o,    // request taken
	input  wire logic [31:0]                wdat_i,         // write data
	output logic                            wdat_ready_o,   // write pop
	output logic      [31:0]                rdat_o,         // read data
	output logic                            rdat_valid_o,   // read strobe
	output logic                            done_o,         // burst ended
	output logic                            abort_o,        // ended early
	input  wire logic [1:0]                 read_cmd_enhance_field_i, // mode
	input  wire logic [2:0]                 func_irq_i,     // irq per func
	input  wire dma_master_pkg::pci_in_t    pin_i,          // bus levels
	output dma_master_pkg::pci_drv_t        pin_o,          // bus drive
	output dma_master_pkg::pci_oe_t         pin_oe_o,       // bus enables
	output logic      [2:0]                 int_b_o,        // irq pins
	output logic      [2:0]                 int_oe_o        // irq enables
);

	typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} mst_t;
	typedef enum logic [1:0] {T_IDLE, T_RETRY, T_TURN} tgt_t;

	mst_t                               mst_reg;
	mst_t                               mst_next;
	tgt_t                               tgt_reg;
	tgt_t                               tgt_next;
	dma_master_pkg::dma_req_t           req_reg;
	logic [dma_master_pkg::PHASE_W-1:0] rem_reg;
	logic [dma_master_pkg::PHASE_W-1:0] rem_next;
	logic [2:0]                         dsel_cnt_reg;
	logic                               frame_q_reg;
	logic [2:0]                         irq_reg;
	logic [3:0]                         cmd;
	dma_master_pkg::pci_drv_t           drv_reg;
	dma_master_pkg::pci_drv_t           drv_next;
	dma_master_pkg::pci_oe_t            oe_reg;
	dma_master_pkg::pci_oe_t            oe_next;

	wire accept     = (mst_reg == M_IDLE) && req_valid_i;
	wire bus_idle   = pin_i.frame_b && pin_i.irdy_b;
	wire granted    = !pin_i.gnt_b;
	wire in_data    = mst_reg == M_DATA;
	wire xfer       = in_data && !drv_reg.irdy_b && !pin_i.trdy_b &&
	                  !pin_i.devsel_b;
	wire tgt_stop   = in_data && !pin_i.stop_b && !pin_i.devsel_b;
	wire last       = rem_reg == dma_master_pkg::LAST_PHASE;
	wire dsel_tmo   = in_data && pin_i.devsel_b &&
	                  dsel_cnt_reg == dma_master_pkg::DEVSEL_TIMEOUT;
	wire end_now    = (last && (xfer || tgt_stop)) || dsel_tmo;
	wire wload      = req_reg.write &&
	                  ((mst_reg == M_ADDR) || (xfer && !last));
	wire mst_busy   = (mst_reg == M_ADDR) || in_data;
	wire addr_phase = !pin_i.frame_b && frame_q_reg && !mst_busy;
	wire mem_cmd    = (pin_i.cbe_b == dma_master_pkg::CMD_MEM_READ) ||
	                  (pin_i.cbe_b == dma_master_pkg::CMD_MEM_WRITE);
	wire tgt_hit    = (tgt_reg == T_IDLE) && addr_phase && mem_cmd &&
	                  ((pin_i.ad & TGT_MASK) == TGT_BASE);
	wire next_owns  = (mst_next == M_ADDR) || (mst_next == M_DATA) ||
	                  (mst_next == M_TURN);

	assign req_ready_o  = accept;
	assign wdat_ready_o = wload;

	bus_cmd_select u_cmd (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.load_i  (accept),
		.req_i   (req_i),
		.enh_i   (read_cmd_enhance_field_i),
		.cmd_o   (cmd)
	);

	always_comb
	begin
		mst_next = mst_reg;
		rem_next = rem_reg;
		case (mst_reg)
			M_IDLE: if (req_valid_i) mst_next = M_REQ;
			// wait for grant on an idle bus, target side quiet
			M_REQ: if (granted && bus_idle && tgt_reg == T_IDLE)
				mst_next = M_ADDR;
			M_ADDR: mst_next = M_DATA;
			M_DATA:
			begin
				if (end_now)
					mst_next = M_TURN;
				else if (tgt_stop)
					rem_next = dma_master_pkg::LAST_PHASE;
				else if (xfer)
					rem_next = rem_reg - dma_master_pkg::LAST_PHASE;
			end
			M_TURN: mst_next = M_IDLE;
			default: mst_next = M_IDLE;
		endcase
	end

	always_comb
	begin
		tgt_next = tgt_reg;
		case (tgt_reg)
			// retry every hit: no target data path behind this window
			T_IDLE: if (tgt_hit) tgt_next = T_RETRY;
			T_RETRY: if (pin_i.frame_b) tgt_next = T_TURN;
			T_TURN: tgt_next = T_IDLE;
			default: tgt_next = T_IDLE;
		endcase
	end

	// pin values follow next state so they line up with the state register
	always_comb
	begin
		drv_next          = drv_reg;
		drv_next.req_b    = !(mst_next == M_REQ);
		drv_next.frame_b  = !((mst_next == M_ADDR) || ((mst_next == M_DATA) &&
		                    (rem_next != dma_master_pkg::LAST_PHASE)));
		drv_next.irdy_b   = !(mst_next == M_DATA);
		// encodings go out on the active-low lines as they stand
		drv_next.cbe_b    = (mst_next == M_ADDR) ? cmd :
		                    dma_master_pkg::BE_ALL_LANES;
		drv_next.par      = ^{drv_reg.ad, drv_reg.cbe_b};
		drv_next.devsel_b = !(tgt_next == T_RETRY);
		drv_next.stop_b   = !(tgt_next == T_RETRY);
		drv_next.trdy_b   = dma_master_pkg::PIN_INACTIVE;
		if (mst_next == M_ADDR)
			drv_next.ad = req_reg.addr;
		else if (wload)
			drv_next.ad = wdat_i;
		oe_next.req    = 1'b1;
		oe_next.frame  = next_owns;
		oe_next.irdy   = next_owns;
		oe_next.cbe    = (mst_next == M_ADDR) || (mst_next == M_DATA);
		oe_next.ad     = (mst_next == M_ADDR) ||
		                 ((mst_next == M_DATA) && req_reg.write);
		oe_next.par    = oe_reg.ad;
		oe_next.devsel = tgt_next != T_IDLE;
		oe_next.stop   = tgt_next != T_IDLE;
		oe_next.trdy   = tgt_next != T_IDLE;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mst_reg      <= M_IDLE;
			tgt_reg      <= T_IDLE;
			req_reg      <= '0;
			rem_reg      <= '0;
			dsel_cnt_reg <= dma_master_pkg::DEVSEL_CNT_RST;
			frame_q_reg  <= dma_master_pkg::PIN_INACTIVE;
			irq_reg      <= 3'h0;
			drv_reg      <= '1;
			oe_reg       <= '0;
			rdat_o       <= 32'h0000_0000;
			rdat_valid_o <= 1'b0;
			done_o       <= 1'b0;
			abort_o      <= 1'b0;
		end
		else
		begin
			mst_reg      <= mst_next;
			tgt_reg      <= tgt_next;
			rem_reg      <= accept ? req_i.phases : rem_next;
			if (accept)
				req_reg  <= req_i;
			dsel_cnt_reg <= (in_data && pin_i.devsel_b) ?
			                dsel_cnt_reg + 3'h1 :
			                dma_master_pkg::DEVSEL_CNT_RST;
			frame_q_reg  <= pin_i.frame_b;
			irq_reg      <= func_irq_i;
			drv_reg      <= drv_next;
			oe_reg       <= oe_next;
			if (xfer && !req_reg.write)
				rdat_o   <= pin_i.ad;
			rdat_valid_o <= xfer && !req_reg.write;
			done_o       <= in_data && end_now;
			abort_o      <= in_data && end_now && (dsel_tmo || !last ||
			                (tgt_stop && !xfer));
		end
	end

	// enables drop the moment reset asserts, without waiting for a clock
	assign pin_o    = drv_reg;
	assign pin_oe_o = rst_b_i ? oe_reg : '0;
	// open-drain interrupts: only ever pull low
	assign int_b_o  = 3'h0;
	assign int_oe_o = rst_b_i ? irq_reg : 3'h0;

	sequence s_addr;
		mst_reg == M_ADDR && !pin_o.frame_b && pin_oe_o.frame;
	endsequence
	sequence s_first_data;
		mst_reg == M_DATA && !pin_o.irdy_b && pin_oe_o.irdy;
	endsequence

	property p_read_cmds;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_addr and (!req_reg.write) |-> (pin_o.cbe_b) inside
		{dma_master_pkg::CMD_MEM_READ, dma_master_pkg::CMD_MEM_READ_MULT,
		 dma_master_pkg::CMD_MEM_READ_LINE};
	endproperty
	a_read_cmds: assert property (p_read_cmds)
		else $error("illegal read command in address phase");

	property p_write_cmds;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_addr and (req_reg.write) |-> (pin_o.cbe_b) inside
		{dma_master_pkg::CMD_MEM_WRITE, dma_master_pkg::CMD_MEM_WRITE_INV};
	endproperty
	a_write_cmds: assert property (p_write_cmds)
		else $error("illegal write command in address phase");

	property p_short_on_pins;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_addr and (!req_reg.write &&
		rem_reg <= dma_master_pkg::SHORT_READ_MAX)
		|-> pin_o.cbe_b == dma_master_pkg::CMD_MEM_READ;
	endproperty
	a_short_on_pins: assert property (p_short_on_pins)
		else $error("short read used enhanced command");

	property p_reset_float;
		@(posedge clk_i) !rst_b_i |-> pin_oe_o == '0 && int_oe_o == 3'h0;
	endproperty
	a_reset_float: assert property (p_reset_float)
		else $error("driver enabled during reset");

	property p_grant_first;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_addr |-> $past(!pin_i.gnt_b) && $past(!pin_o.req_b);
	endproperty
	a_grant_first: assert property (p_grant_first)
		else $error("address phase without grant");

	property p_addr_then_data;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_addr |=> s_first_data;
	endproperty
	a_addr_then_data: assert property (p_addr_then_data)
		else $error("no data phase after address phase");

	property p_retry;
		@(posedge clk_i) disable iff (!rst_b_i)
		tgt_hit |=> !pin_o.devsel_b && !pin_o.stop_b && pin_o.trdy_b &&
		pin_oe_o.devsel && pin_oe_o.stop;
	endproperty
	a_retry: assert property (p_retry)
		else $error("target hit not retried");

	property p_irq_pin;
		@(posedge clk_i) disable iff (!rst_b_i)
		func_irq_i[1] |=> int_oe_o[1] && !int_b_o[1];
	endproperty
	a_irq_pin: assert property (p_irq_pin)
		else $error("function 1 interrupt pin not pulled");

	property p_master_abort;
		@(posedge clk_i) disable iff (!rst_b_i)
		(in_data && pin_i.devsel_b) [*6] |=> done_o && abort_o &&
		mst_reg == M_TURN;
	endproperty
	a_master_abort: assert property (p_master_abort)
		else $error("missing master abort after devsel timeout");

endmodule : dma_pci_master

// file: rtl/dma_master_pkg.sv
// constants and carrier types for the dma bus-master front end
// assumes a 32-bit multiplexed address/data bus with active-low controls
package dma_master_pkg;

	// bus command encodings on the command/byte-enable lines
	localparam logic [3:0] CMD_MEM_READ      = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
	localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF;
	localparam logic [3:0] BE_ALL_LANES      = 4'h0;

	// read_cmd_enhance_field codes; the fourth code falls back to plain read
	localparam logic [1:0] ENH_MEM_READ  = 2'h0;
	localparam logic [1:0] ENH_READ_LINE = 2'h1;
	localparam logic [1:0] ENH_READ_MULT = 2'h2;

	localparam int PHASE_W = 8;
	localparam logic [PHASE_W-1:0] SHORT_READ_MAX = 8'h02;
	localparam logic [PHASE_W-1:0] LAST_PHASE     = 8'h01;

	// cycles without devsel before the master gives up
	localparam logic [2:0] DEVSEL_TIMEOUT = 3'h5;
	localparam logic [2:0] DEVSEL_CNT_RST = 3'h0;
	localparam logic       PIN_INACTIVE   = 1'b1;

	typedef struct packed {
		logic               write;
		logic               mwi_ok;
		logic [31:0]        addr;
		logic [PHASE_W-1:0] phases;
	} dma_req_t;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_b;
		logic        frame_b;
		logic        irdy_b;
		logic        trdy_b;
		logic        devsel_b;
		logic        stop_b;
		logic        gnt_b;
	} pci_in_t;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_b;
		logic        par;
		logic        frame_b;
		logic        irdy_b;
		logic        trdy_b;
		logic        devsel_b;
		logic        stop_b;
		logic        req_b;
	} pci_drv_t;

	typedef struct packed {
		logic ad;
		logic cbe;
		logic par;
		logic frame;
		logic irdy;
		logic trdy;
		logic devsel;
		logic stop;
		logic req;
	} pci_oe_t;

endpackage : dma_master_pkg

// file: rtl/bus_cmd_select.sv
// picks and holds the bus command for one dma request
// assumes load_i pulses once, when the request is accepted
`timescale 1ns/1ps
module bus_cmd_select (
	input  wire logic                              clk_i,    // bus clock
	input  wire logic                              rst_b_i,  // async reset
	input  wire logic                              load_i,   // latch command
	input  wire dma_master_pkg::dma_req_t          req_i,    // dma request
	input  wire logic [1:0]                        enh_i,    // read enhance
	output logic      [3:0]                        cmd_o     // held command
);

	logic [3:0] cmd_next;
	logic       short_read;
	logic [3:0] long_read_cmd;
	logic [3:0] write_cmd;

	assign short_read = req_i.phases <= dma_master_pkg::SHORT_READ_MAX;
	// long reads follow the enhance field; unused code stays plain read
	assign long_read_cmd =
		(enh_i == dma_master_pkg::ENH_READ_LINE) ?
			dma_master_pkg::CMD_MEM_READ_LINE :
		(enh_i == dma_master_pkg::ENH_READ_MULT) ?
			dma_master_pkg::CMD_MEM_READ_MULT :
			dma_master_pkg::CMD_MEM_READ;
	// invalidate only when the source vouches for whole lines
	assign write_cmd = req_i.mwi_ok ? dma_master_pkg::CMD_MEM_WRITE_INV :
		dma_master_pkg::CMD_MEM_WRITE;
	assign cmd_next = req_i.write ? write_cmd :
		short_read ? dma_master_pkg::CMD_MEM_READ :
		long_read_cmd;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cmd_o <= dma_master_pkg::CMD_MEM_READ;
		else if (load_i)
			cmd_o <= cmd_next;
	end

	property p_long_line;
		@(posedge clk_i) disable iff (!rst_b_i)
		(load_i && !req_i.write && !short_read &&
		 enh_i == dma_master_pkg::ENH_READ_LINE)
		|=> cmd_o == dma_master_pkg::CMD_MEM_READ_LINE;
	endproperty
	a_long_line: assert property (p_long_line)
		else $error("long read ignored enhance field");

	property p_short_read;
		@(posedge clk_i) disable iff (!rst_b_i)
		(load_i && !req_i.write && short_read)
		|=> (cmd_o == dma_master_pkg::CMD_MEM_READ) [*1] ##1
		    ($stable(cmd_o) || $past(load_i));
	endproperty
	a_short_read: assert property (p_short_read)
		else $error("short read not plain memory read");

endmodule : bus_cmd_select

// file: dv/pci_host_model.sv
// host side: arbiter plus one memory target, resolves the bus levels
// assumes design drive/enable fields; read data is the beat address
`timescale 1ns/1ps
module pci_host_model (
	input  wire logic                     clk_i,      // bus clock
	input  wire logic                     rst_b_i,    // global reset
	input  wire logic                     grant_en_i, // arbiter may grant
	input  wire logic                     slow_i,     // wait state per beat
	input  wire logic                     nodev_i,    // never claim
	input  wire logic                     ini_i,      // start target probe
	input  wire dma_master_pkg::pci_drv_t drv_i,      // design drive
	input  wire dma_master_pkg::pci_oe_t  oe_i,       // design enables
	output dma_master_pkg::pci_in_t       pin_o,      // resolved levels
	output logic      [3:0]               cmd_o       // last command seen
);
	logic [31:0] addr_reg;
	logic [31:0] last_ad_reg;
	logic        busy_reg;
	logic        trdy_b_reg;
	logic        gnt_b_reg;
	logic        ini_frame_reg;
	logic        frame_b;
	logic        irdy_b;
	logic        req_b;
	logic        xfer;
	// pull-ups on controls; released data lines show inverted history
	assign frame_b = oe_i.frame ? drv_i.frame_b : ~ini_frame_reg;
	assign irdy_b = oe_i.irdy ? drv_i.irdy_b : 1'b1;
	assign req_b = oe_i.req ? drv_i.req_b : 1'b1;
	assign xfer = busy_reg & ~irdy_b & ~trdy_b_reg;
	assign pin_o.frame_b = frame_b;
	assign pin_o.irdy_b = irdy_b;
	assign pin_o.gnt_b = gnt_b_reg;
	assign pin_o.stop_b = oe_i.stop ? drv_i.stop_b : 1'b1;
	assign pin_o.trdy_b = (oe_i.trdy ? drv_i.trdy_b : 1'b1) & trdy_b_reg;
	assign pin_o.devsel_b = (oe_i.devsel ? drv_i.devsel_b : 1'b1)
		& ~busy_reg;
	assign pin_o.cbe_b = oe_i.cbe ? drv_i.cbe_b
		: ini_frame_reg ? dma_master_pkg::CMD_MEM_READ : ~last_ad_reg[3:0];
	// probe address lies in the default target window of the design
	assign pin_o.ad = oe_i.ad ? drv_i.ad
		: ini_frame_reg ? 32'h0000_0040
		: (busy_reg & ~cmd_o[0]) ? addr_reg : ~last_ad_reg;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_reg <= 1'b0;
			trdy_b_reg <= 1'b1;
			gnt_b_reg <= 1'b1;
			ini_frame_reg <= 1'b0;
			addr_reg <= 32'h0000_0000;
			last_ad_reg <= 32'h0000_0000;
			cmd_o <= 4'h0;
		end
		else
		begin
			gnt_b_reg <= ~(grant_en_i & ~req_b);
			last_ad_reg <= pin_o.ad;
			// host as initiator: hold frame until the design stops it
			if (ini_frame_reg)
				ini_frame_reg <= pin_o.stop_b;
			else
				ini_frame_reg <= ini_i & frame_b & ~oe_i.frame;
			if (!busy_reg && !frame_b && !nodev_i && !ini_frame_reg)
			begin
				busy_reg <= 1'b1;
				cmd_o <= pin_o.cbe_b;
				addr_reg <= pin_o.ad;
				trdy_b_reg <= slow_i;
			end
			else if (busy_reg)
			begin
				if (xfer)
					addr_reg <= addr_reg + 32'h0000_0004;
				busy_reg <= ~(xfer & frame_b);
				trdy_b_reg <= (xfer & frame_b) | (slow_i & ~trdy_b_reg);
			end
		end
	end
endmodule : pci_host_model

// file: dv/tb.sv
// scenario bench for the dma bus-master front end
// assumes the host model answers every master cycle unless told not to
`timescale 1ns/1ps
module tb;
	logic                     clk_i;
	logic                     rst_b_i;
	logic                     req_valid_i;
	logic                     grant_en;
	logic                     slow;
	logic                     nodev;
	logic                     ini;
	dma_master_pkg::dma_req_t req_i;
	logic [31:0]              wdat_i;
	logic [31:0]              rdat_o;
	logic                     req_ready_o;
	logic                     wdat_ready_o;
	logic                     rdat_valid_o;
	logic                     done_o;
	logic                     abort_o;
	logic [1:0]               enh;
	logic [2:0]               func_irq_i;
	logic [2:0]               int_b_o;
	logic [2:0]               int_oe_o;
	logic [3:0]               cmd_seen;
	dma_master_pkg::pci_in_t  pin_i;
	dma_master_pkg::pci_drv_t pin_o;
	dma_master_pkg::pci_oe_t  pin_oe_o;
	int                       failures;
	int                       n_checks;
	dma_pci_master dma_pci_master_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.wdat_i(wdat_i), .wdat_ready_o(wdat_ready_o), .rdat_o(rdat_o),
		.rdat_valid_o(rdat_valid_o), .done_o(done_o), .abort_o(abort_o),
		.read_cmd_enhance_field_i(enh), .func_irq_i(func_irq_i),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.int_b_o(int_b_o), .int_oe_o(int_oe_o));
	pci_host_model pci_host_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.grant_en_i(grant_en), .slow_i(slow), .nodev_i(nodev),
		.ini_i(ini),
		.drv_i(pin_o), .oe_i(pin_oe_o), .pin_o(pin_i), .cmd_o(cmd_seen));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// write source never stalls, so it advances on every pop
	always @(posedge clk_i)
		if (wdat_ready_o === 1'b1)
			wdat_i <= wdat_i + 32'h0000_0001;
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic do_op(input logic wr, mwi, input logic [7:0] ph,
		input logic [1:0] e, input logic [3:0] cmd, input logic ab,
		input int hold);
		logic [31:0] exp_d;
		logic [31:0] exp_w;
		int n;
		int beats;
		exp_d = 32'h0001_0100;
		exp_w = wdat_i;
		beats = 0;
		n = 0;
		@(negedge clk_i);
		req_i = '{write: wr, mwi_ok: mwi, addr: exp_d, phases: ph};
		enh = e;
		req_valid_i = 1'b1;
		#1;
		while (req_ready_o !== 1'b1 && n < 50)
		begin
			@(negedge clk_i);
			n++;
		end
		check("request taken", req_ready_o, 1'b1);
		@(negedge clk_i);
		req_valid_i = 1'b0;
		repeat (hold)
		begin
			@(negedge clk_i);
			check("frame oe before grant", pin_oe_o.frame, 1'b0);
		end
		grant_en = 1'b1;
		n = 0;
		do
		begin
			@(negedge clk_i);
			if (rdat_valid_o === 1'b1)
			begin
				check("read data", rdat_o, exp_d);
				exp_d = exp_d + 32'h0000_0004;
				beats++;
			end
			// write beat: irdy, trdy and devsel all low mid-cycle
			if (wr && pin_o.irdy_b === 1'b0 && pin_i.trdy_b === 1'b0 &&
			    pin_i.devsel_b === 1'b0)
			begin
				check("write data", pin_o.ad, exp_w);
				exp_w = exp_w + 32'h0000_0001;
				beats++;
			end
			n++;
		end
		while (done_o !== 1'b1 && n < 200);
		check("done", done_o, 1'b1);
		check("abort", abort_o, ab);
		if (!ab)
			check("command", cmd_seen, cmd);
		if (!ab)
			check("beats", beats, ph);
	endtask : do_op
	task automatic t_reads();
		logic [3:0] exp [4];
		exp = '{4'h6, 4'hE, 4'hC, 4'h6};
		for (int i = 0; i < 4; i++)
		begin
			slow = i[0];
			do_op(1'b0, 1'b0, 8'h03, i[1:0], exp[i], 1'b0, 0);
		end
		for (int i = 1; i < 3; i++)
			do_op(1'b0, 1'b0, i[7:0], i[1:0], 4'h6, 1'b0, 0);
	endtask : t_reads
	task automatic t_writes();
		do_op(1'b1, 1'b0, 8'h02, 2'h1, 4'h7, 1'b0, 0);
		do_op(1'b1, 1'b1, 8'h04, 2'h2, 4'hF, 1'b0, 0);
	endtask : t_writes
	task automatic t_grant_abort();
		grant_en = 1'b0;
		do_op(1'b0, 1'b0, 8'h05, 2'h2, 4'hC, 1'b0, 8);
		nodev = 1'b1;
		do_op(1'b0, 1'b0, 8'h02, 2'h0, 4'h6, 1'b1, 0);
		nodev = 1'b0;
	endtask : t_grant_abort
	task automatic t_irq();
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk_i);
			func_irq_i = 3'h1 << i;
			@(negedge clk_i);
			check("irq enable", int_oe_o, 3'h1 << i);
			check("irq level", int_b_o, 3'h0);
		end
	endtask : t_irq
	// host starts a read into the target window; design must retry it
	task automatic t_target();
		@(negedge clk_i);
		ini = 1'b1;
		@(negedge clk_i);
		ini = 1'b0;
		@(negedge clk_i);
		check("target devsel", pin_o.devsel_b, 1'b0);
		check("target stop", pin_o.stop_b, 1'b0);
		check("target trdy", pin_o.trdy_b, 1'b1);
		check("target stop oe", pin_oe_o.stop, 1'b1);
		repeat (3) @(negedge clk_i);
		check("target released", pin_oe_o.devsel, 1'b0);
	endtask : t_target
	task automatic t_mid_reset();
		int n;
		n = 0;
		@(negedge clk_i);
		func_irq_i = 3'h7;
		req_i = '{write: 1'b0, mwi_ok: 1'b0, addr: 32'h0002_0000,
			phases: 8'h08};
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		while (pin_oe_o.frame !== 1'b1 && n < 50)
		begin
			@(negedge clk_i);
			n++;
		end
		check("burst started", pin_oe_o.frame, 1'b1);
		rst_b_i = 1'b0;
		#1;
		check("pin enables", {23'h0, pin_oe_o}, 32'h0);
		check("irq enables", int_oe_o, 3'h0);
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		func_irq_i = 3'h0;
		do_op(1'b0, 1'b0, 8'h01, 2'h1, 4'h6, 1'b0, 0);
	endtask : t_mid_reset
	initial
	begin
		#(30000 * 5);
		failures++;
		conclude();
	end
	initial
	begin
		failures = 0;
		n_checks = 0;
		rst_b_i = 1'b0;
		req_valid_i = 1'b0;
		req_i = '0;
		wdat_i = 32'hC0DE_0000;
		enh = 2'h0;
		func_irq_i = 3'h5;
		grant_en = 1'b1;
		slow = 1'b0;
		nodev = 1'b0;
		ini = 1'b0;
		repeat (16) @(negedge clk_i);
		check("pin enables", {23'h0, pin_oe_o}, 32'h0);
		check("irq enables", int_oe_o, 3'h0);
		rst_b_i = 1'b1;
		t_reads();
		t_writes();
		t_grant_abort();
		t_irq();
		t_target();
		t_mid_reset();
		conclude();
	end
endmodule : tb
